// ==== rftis_regs.vh ====
// Register map and constants for the receive queue, timer and interrupt block.
// Assumes a 32-bit Avalon-MM slave with word addresses in byte units.
`ifndef RFTIS_REGS_VH
`define RFTIS_REGS_VH

`define RFTIS_DEPTH 8
`define RFTIS_PTR_W 3
`define RFTIS_CNT_W 4
`define RFTIS_PAYLOAD_BYTES 32
`define RFTIS_PAYLOAD_W 256
`define RFTIS_ENTRY_WORDS 8
`define RFTIS_STAT_W 16

`define RFTIS_ADDR_W 8
`define RFTIS_OFF_QSTAT 8'h00
`define RFTIS_OFF_QCFG 8'h04
`define RFTIS_OFF_QHEAD 8'h08
`define RFTIS_OFF_QPOP 8'h0C
`define RFTIS_OFF_T0CFG 8'h10
`define RFTIS_OFF_T1CFG 8'h14
`define RFTIS_OFF_TCTL 8'h18
`define RFTIS_OFF_ISTAT 8'h1C
`define RFTIS_OFF_IEN 8'h20
`define RFTIS_OFF_IMAP 8'h24
`define RFTIS_OFF_DATA 8'h40

`define RFTIS_NSRC 5
`define RFTIS_SRC_T0 0
`define RFTIS_SRC_T1 1
`define RFTIS_SRC_CYC 2
`define RFTIS_SRC_PST 3
`define RFTIS_SRC_QTH 4

`define RFTIS_IEN_GLOBAL 31
`define RFTIS_QSTAT_OVR 16
`define RFTIS_QCFG_RST 8'h02
`define RFTIS_IMAP_RST 5'h00

`define RFTIS_MT_W 14
`define RFTIS_CYC_W 6
`define RFTIS_TCFG_CYCEN 20
`define RFTIS_TCFG_REP 21
`define RFTIS_TCFG_CYC_LSB 14

`define RFTIS_ST_W 3
`define RFTIS_ST_HALT 3'h1
`define RFTIS_ST_READY 3'h2
`define RFTIS_ST_FULL 3'h3
`define RFTIS_ST_LISTEN 3'h4

`endif

// ==== rftis_core.v ====
// Receive queue, two absolute macrotick timers and interrupt service.
// Assumes protocol engine inputs are synchronous to i_core_clk and that
// a store strobe carries one whole admitted frame, already filtered.
// Operation
// - One queued receive structure stores admitted frames for the host.
// - Queue holds eight frames with payload and slot status, no overwrite.
// - Entry width equals the largest single receive buffer payload.
// - Longer payloads keep only leading bytes up to the configured width.
// - Eight entries at full width exist together.
// - Frames from either channel or any mix share the queue.
// - Simultaneous frames on both channels are both queued; code queues only channel A when room is one entry.
// - Host reads frames strictly in arrival order.
// - Occupied entry count is reported.
// - Overrun flag sticks when a frame finds the queue full until cleared.
// - Free entry count is reported.
// - Frame dropping free entries below threshold raises queue interrupt; code compares only threshold bits 2:0, and bit 3 fires on full.
// - Two absolute timers, each able to notify the host.
// - Expiry at macrotick in given cycle or at macrotick every cycle.
// - Single-shot and repeating timer modes.
// - Timers run in participation states; deactivated when leaving them.
// - Host may deactivate timer; reactivation needed before expiry.
// - Cycle start is its own interrupt source.
// - State change event on entry to halt, ready, full or listen only; code raises none while i_abrupt_cmd is high.
// - Sources map to request lines; timer zero owns a dedicated line.
// - Per-source enables plus global disable gate requests.
// - Sticky status flag per source until host clears it.
// - Status flags set regardless of enables.
// - Cycle compare field is six bits, values zero to 63.
//
// The implementer's own choices: the Avalon-MM interface to the registers and the placing of the registers.
`include "rftis_regs.vh"

module rftis_core (
    input wire i_core_clk,
    input wire i_rst_n,
    input wire [`RFTIS_ADDR_W-1:0] i_avs_address,
    input wire i_avs_read,
    input wire i_avs_write,
    input wire [31:0] i_avs_writedata,
    input wire [3:0] i_avs_byteenable,
    output reg [31:0] o_avs_readdata,
    output reg o_avs_waitrequest,
    output reg [1:0] o_avs_response,
    input wire i_rx_a_valid,
    input wire [`RFTIS_PAYLOAD_W-1:0] i_rx_a_payload,
    input wire [7:0] i_rx_a_len,
    input wire [`RFTIS_STAT_W-1:0] i_rx_a_status,
    input wire i_rx_b_valid,
    input wire [`RFTIS_PAYLOAD_W-1:0] i_rx_b_payload,
    input wire [7:0] i_rx_b_len,
    input wire [`RFTIS_STAT_W-1:0] i_rx_b_status,
    input wire [`RFTIS_MT_W-1:0] i_macrotick,
    input wire [`RFTIS_CYC_W-1:0] i_cycle_count,
    input wire i_cycle_start,
    input wire [`RFTIS_ST_W-1:0] i_protocol_state,
    input wire i_abrupt_cmd,
    output reg o_irq_timer0,
    output reg o_irq_shared
);
    localparam BUS_IDLE = 2'b01;
    localparam BUS_ANS = 2'b10;

    reg [1:0] bus_st;
    reg [`RFTIS_PAYLOAD_W-1:0] q_pay [0:`RFTIS_DEPTH-1];
    reg [`RFTIS_STAT_W-1:0] q_stat [0:`RFTIS_DEPTH-1];
    reg [7:0] q_len [0:`RFTIS_DEPTH-1];
    reg [`RFTIS_PTR_W-1:0] wr_ptr, rd_ptr;
    reg [`RFTIS_CNT_W-1:0] q_cnt;
    reg overrun;
    reg [7:0] q_cfg;
    reg [31:0] t_cfg [0:1];
    wire [1:0] t_act;
    wire [`RFTIS_NSRC-1:0] i_stat;
    reg [`RFTIS_NSRC-1:0] i_en;
    reg [`RFTIS_NSRC-1:0] i_map;
    reg g_en;
    reg [`RFTIS_ST_W-1:0] st_q;
    reg [`RFTIS_MT_W-1:0] mt_q;
    localparam [`RFTIS_CNT_W-1:0] Q_DEPTH = `RFTIS_DEPTH;

    function [`RFTIS_PAYLOAD_W-1:0] trunc_pay;
        input [`RFTIS_PAYLOAD_W-1:0] pay;
        input [7:0] len;
        input [7:0] lim;
        integer b;
        reg [7:0] keep;
        begin
            keep = (len < lim) ? len : lim;
            trunc_pay = {`RFTIS_PAYLOAD_W{1'b0}};
            for (b = 0; b < `RFTIS_PAYLOAD_BYTES; b = b + 1) begin
                if (b < keep)
                    trunc_pay[b*8 +: 8] = pay[b*8 +: 8];
            end
        end
    endfunction

    function is_part;
        input [`RFTIS_ST_W-1:0] s;
        begin
            is_part = (s == `RFTIS_ST_FULL) || (s == `RFTIS_ST_LISTEN);
        end
    endfunction

    // Configured width limit, clamped to the hardware width
    wire [7:0] lim_bytes = (q_cfg == 8'h00 ||
        q_cfg > `RFTIS_PAYLOAD_BYTES) ? 8'd`RFTIS_PAYLOAD_BYTES : q_cfg;
    wire [`RFTIS_CNT_W-1:0] q_free = Q_DEPTH - q_cnt;
    reg [3:0] q_thr;

    // Commit in the answer cycle, the edge where waitrequest is seen low
    wire acc = (i_avs_read | i_avs_write) & (bus_st == BUS_ANS);
    wire wr = i_avs_write & acc;
    wire pop = i_avs_read & acc & (i_avs_address == `RFTIS_OFF_QPOP)
        & (q_cnt != 0);
    wire wr_ok = wr & (i_avs_byteenable == 4'hF);

    // Both channels may deliver together; two slots if room, A first
    wire [`RFTIS_CNT_W-1:0] room = q_free + {3'h0, pop};
    wire take_a = i_rx_a_valid & (room != 0);
    wire take_b = i_rx_b_valid & (room > {3'h0, i_rx_a_valid});
    wire lose = (i_rx_a_valid & ~take_a) | (i_rx_b_valid & ~take_b);
    wire [1:0] n_in = {1'b0, take_a} + {1'b0, take_b};
    wire [`RFTIS_CNT_W-1:0] next_cnt = q_cnt + {2'h0, n_in} -
        {3'h0, pop};
    wire q_event = (n_in != 0) && (next_cnt > q_cnt ? 1'b1 : n_in != 0)
        && ((`RFTIS_DEPTH - next_cnt) < {1'b0, q_thr[2:0]} ||
            (q_thr[3] && next_cnt == `RFTIS_DEPTH));

    // Timer expiry, driven from the per-timer generate loop below
    wire [1:0] t_hit;

    wire st_chg = (i_protocol_state != st_q) && !i_abrupt_cmd &&
        (i_protocol_state == `RFTIS_ST_HALT ||
         i_protocol_state == `RFTIS_ST_READY || is_part(i_protocol_state));
    wire leave_part = is_part(st_q) && !is_part(i_protocol_state);

    wire [`RFTIS_NSRC-1:0] ev;
    assign ev[`RFTIS_SRC_T0] = t_hit[0];
    assign ev[`RFTIS_SRC_T1] = t_hit[1];
    assign ev[`RFTIS_SRC_CYC] = i_cycle_start;
    assign ev[`RFTIS_SRC_PST] = st_chg;
    assign ev[`RFTIS_SRC_QTH] = q_event;

    wire [`RFTIS_NSRC-1:0] clr = (wr_ok &&
        i_avs_address == `RFTIS_OFF_ISTAT) ?
        i_avs_writedata[`RFTIS_NSRC-1:0] : {`RFTIS_NSRC{1'b0}};
    wire [`RFTIS_NSRC-1:0] next_stat = (i_stat & ~clr) | ev;
    wire [`RFTIS_NSRC-1:0] req = next_stat & i_en & {`RFTIS_NSRC{g_en}};

    // Queue storage and pointers
    always @(posedge i_core_clk) begin
        if (take_a) begin
            q_pay[wr_ptr] <= trunc_pay(i_rx_a_payload, i_rx_a_len,
                lim_bytes);
            q_stat[wr_ptr] <= i_rx_a_status;
            q_len[wr_ptr] <= (i_rx_a_len < lim_bytes) ? i_rx_a_len : lim_bytes;
        end
        if (take_b) begin
            q_pay[wr_ptr + {2'h0, take_a}] <= trunc_pay(i_rx_b_payload,
                i_rx_b_len, lim_bytes);
            q_stat[wr_ptr + {2'h0, take_a}] <= i_rx_b_status;
            q_len[wr_ptr + {2'h0, take_a}] <= (i_rx_b_len < lim_bytes) ?
                i_rx_b_len : lim_bytes;
        end
    end

    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_ptr <= {`RFTIS_PTR_W{1'b0}};
            rd_ptr <= {`RFTIS_PTR_W{1'b0}};
            q_cnt <= {`RFTIS_CNT_W{1'b0}};
            overrun <= 1'b0;
        end else begin
            wr_ptr <= wr_ptr + {1'b0, n_in};
            if (pop)
                rd_ptr <= rd_ptr + 3'h1;
            q_cnt <= next_cnt;
            if (lose)
                overrun <= 1'b1;
            else if (wr_ok && i_avs_address == `RFTIS_OFF_QSTAT &&
                     i_avs_writedata[`RFTIS_QSTAT_OVR])
                overrun <= 1'b0;
        end
    end

    // Full-word write to one register offset, on the committing edge
    function wr_at;
        input [`RFTIS_ADDR_W-1:0] a;
        input [`RFTIS_ADDR_W-1:0] off;
        input ok;
        begin
            wr_at = ok && (a == off);
        end
    endfunction

    // Protocol state and macrotick history for change detection
    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_q <= {`RFTIS_ST_W{1'b0}};
            mt_q <= {`RFTIS_MT_W{1'b0}};
        end else begin
            st_q <= i_protocol_state;
            mt_q <= i_macrotick;
        end
    end

    // Queue width limit and threshold
    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            q_cfg <= `RFTIS_QCFG_RST;
            q_thr <= 4'h0;
        end else if (wr_at(i_avs_address, `RFTIS_OFF_QCFG, wr_ok)) begin
            q_cfg <= i_avs_writedata[7:0];
            q_thr <= i_avs_writedata[11:8];
        end
    end

    // Timer set-up words; a write also disarms the timer below
    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            t_cfg[0] <= 32'h0000_0000;
            t_cfg[1] <= 32'h0000_0000;
        end else begin
            if (wr_at(i_avs_address, `RFTIS_OFF_T0CFG, wr_ok))
                t_cfg[0] <= i_avs_writedata;
            if (wr_at(i_avs_address, `RFTIS_OFF_T1CFG, wr_ok))
                t_cfg[1] <= i_avs_writedata;
        end
    end

    // Each timer owns its arming flag and its match logic
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_timer
            reg armed;
            wire [31:0] cfg = t_cfg[g];
            wire cfg_wr = wr_at(i_avs_address,
                (g == 0) ? `RFTIS_OFF_T0CFG : `RFTIS_OFF_T1CFG, wr_ok);
            wire ctl_wr = wr_at(i_avs_address, `RFTIS_OFF_TCTL, wr_ok) &&
                is_part(i_protocol_state);
            wire cyc_ok = !cfg[`RFTIS_TCFG_CYCEN] || i_cycle_count ==
                cfg[`RFTIS_TCFG_CYC_LSB +: `RFTIS_CYC_W];

            // Fire only on the tick that moves onto the match value
            assign t_hit[g] = armed && (mt_q != i_macrotick) &&
                (i_macrotick == cfg[`RFTIS_MT_W-1:0]) &&
                cyc_ok;
            assign t_act[g] = armed;

            always @(posedge i_core_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    armed <= 1'b0;
                end else if (leave_part) begin
                    armed <= 1'b0;
                end else if (cfg_wr) begin
                    armed <= 1'b0;
                end else if (ctl_wr) begin
                    armed <= i_avs_writedata[g];
                end else if (t_hit[g] && !cfg[`RFTIS_TCFG_REP]) begin
                    armed <= 1'b0;
                end
            end
        end
    endgenerate

    // One sticky flag per source; an event in the clearing cycle wins
    genvar s;
    generate
        for (s = 0; s < `RFTIS_NSRC; s = s + 1) begin : g_flag
            reg flag;

            always @(posedge i_core_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    flag <= 1'b0;
                end else if (ev[s]) begin
                    flag <= 1'b1;
                end else if (clr[s]) begin
                    flag <= 1'b0;
                end
            end
            assign i_stat[s] = flag;
        end
    endgenerate

    // Source enables, global enable and shared-line map
    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            i_en <= {`RFTIS_NSRC{1'b0}};
            g_en <= 1'b0;
            i_map <= `RFTIS_IMAP_RST;
        end else begin
            if (wr_at(i_avs_address, `RFTIS_OFF_IEN, wr_ok)) begin
                i_en <= i_avs_writedata[`RFTIS_NSRC-1:0];
                g_en <= i_avs_writedata[`RFTIS_IEN_GLOBAL];
            end
            // Timer zero cannot be mapped off the shared line
            if (wr_at(i_avs_address, `RFTIS_OFF_IMAP, wr_ok))
                i_map <= i_avs_writedata[`RFTIS_NSRC-1:0] & 5'h1E;
        end
    end

    // Request lines
    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_irq_timer0 <= 1'b0;
            o_irq_shared <= 1'b0;
        end else begin
            // Timer zero has a line of its own and always drives line two too; other sources share line two unless mapped off
            o_irq_timer0 <= req[`RFTIS_SRC_T0];
            o_irq_shared <= |(req & ~i_map);
        end
    end

    // Avalon slave: waitrequest low one cycle after the request is seen;
    // writes and pops land at the edge where the master sees it low
    wire [2:0] word = i_avs_address[4:2];
    reg [31:0] next_rdata;
    reg [1:0] next_resp;

    always @* begin
        next_rdata = 32'h0000_0000;
        next_resp = 2'b00;
        if (i_avs_address >= `RFTIS_OFF_DATA &&
            i_avs_address < `RFTIS_OFF_DATA + 8'h20) begin
            next_rdata = q_pay[rd_ptr][word*32 +: 32];
        end else begin
            case (i_avs_address)
                `RFTIS_OFF_QSTAT:
                    next_rdata = {15'h0, overrun, 4'h0, q_free, 4'h0, q_cnt};
                `RFTIS_OFF_QCFG:
                    next_rdata = {20'h0, q_thr, q_cfg};
                `RFTIS_OFF_QHEAD, `RFTIS_OFF_QPOP:
                    next_rdata = {8'h0, q_len[rd_ptr], q_stat[rd_ptr]};
                `RFTIS_OFF_T0CFG:
                    next_rdata = t_cfg[0];
                `RFTIS_OFF_T1CFG:
                    next_rdata = t_cfg[1];
                `RFTIS_OFF_TCTL:
                    next_rdata = {30'h0, t_act};
                `RFTIS_OFF_ISTAT:
                    next_rdata = {27'h0, i_stat};
                `RFTIS_OFF_IEN:
                    next_rdata = {g_en, 26'h0, i_en};
                `RFTIS_OFF_IMAP:
                    next_rdata = {27'h0, i_map};
                // Holes answer with an error code and zero data
                default:
                    next_resp = 2'b10;
            endcase
        end
    end

    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            bus_st <= BUS_IDLE;
            o_avs_waitrequest <= 1'b1;
            o_avs_readdata <= 32'h0000_0000;
            o_avs_response <= 2'b00;
        end else begin
            case (bus_st)
                BUS_IDLE: begin
                    if (i_avs_read | i_avs_write) begin
                        bus_st <= BUS_ANS;
                        o_avs_waitrequest <= 1'b0;
                        o_avs_response <= next_resp;
                        o_avs_readdata <= next_rdata;
                    end
                end
                BUS_ANS: begin
                    bus_st <= BUS_IDLE;
                    o_avs_waitrequest <= 1'b1;
                end
                default: begin
                    bus_st <= BUS_IDLE;
                    o_avs_waitrequest <= 1'b1;
                end
            endcase
        end
    end
endmodule // rftis_core

// ==== rftis_core_properties.sv ====
// Bus and request-line properties of the receive queue and timer block.
// Sees only the top module's ports; attached by the bind at the foot.
module rftis_core_properties (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic [7:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    input wire logic [1:0] o_avs_response,
    input wire logic o_irq_timer0,
    input wire logic o_irq_shared
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    logic req;
    assign req = i_avs_read | i_avs_write;
    property p_take;
        req && o_avs_waitrequest |=> !o_avs_waitrequest;
    endproperty
    a_take: assert property (p_take) else $error("no answer");
    property p_short;
        !o_avs_waitrequest |=> o_avs_waitrequest;
    endproperty
    a_short: assert property (p_short) else $error("long answer");
    property p_cause;
        !o_avs_waitrequest |-> $past(req);
    endproperty
    a_cause: assert property (p_cause) else $error("idle answer");
    property p_unmap;
        !o_avs_waitrequest && $past(i_avs_address) inside {[8'h28:8'h3C]}
            |-> o_avs_response == 2'b10;
    endproperty
    a_unmap: assert property (p_unmap) else $error("hole not refused");
    property p_map;
        !o_avs_waitrequest && $past(i_avs_address) < 8'h28
            |-> o_avs_response == 2'b00;
    endproperty
    a_map: assert property (p_map) else $error("mapped refused");
    property p_hold;
        o_avs_waitrequest && !req |=> $stable(o_avs_readdata);
    endproperty
    a_hold: assert property (p_hold) else $error("readdata moved");
    // Flags are sticky, so a request only drops after a host write
    property p_t0fall;
        $fell(o_irq_timer0) |-> $past(i_avs_write) || $past(i_avs_write, 2)
            || $past(i_avs_write, 3);
    endproperty
    a_t0fall: assert property (p_t0fall) else $error("t0 dropped");
    property p_shfall;
        $fell(o_irq_shared) |-> $past(i_avs_write) || $past(i_avs_write, 2)
            || $past(i_avs_write, 3);
    endproperty
    a_shfall: assert property (p_shfall) else $error("shared dropped");
    c_hole: cover property (!o_avs_waitrequest && o_avs_response == 2'b10);
    c_t0: cover property ($rose(o_irq_timer0));
    c_sh: cover property ($rose(o_irq_shared));
endmodule // rftis_core_properties

bind rftis_core rftis_core_properties rftis_core_properties_inst (
    .i_core_clk, .i_rst_n, .i_avs_address, .i_avs_read, .i_avs_write,
    .o_avs_readdata, .o_avs_waitrequest, .o_avs_response, .o_irq_timer0,
    .o_irq_shared);

// ==== rftis_engine_model.sv ====
// Protocol engine stand-in: live macrotick and cycle counters.
// Assumes one macrotick per two core clocks; short cycle keeps runs brief.
module rftis_engine_model #(parameter int MT_LAST = 39) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    output logic [13:0] o_macrotick,
    output logic [5:0] o_cycle_count,
    output logic o_cycle_start
);
    timeunit 1ns;
    timeprecision 100ps;
    logic ph;
    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ph <= 1'b0;
            o_macrotick <= 14'h0;
            o_cycle_count <= 6'h0;
            o_cycle_start <= 1'b0;
        end else begin
            ph <= !ph;
            o_cycle_start <= 1'b0;
            if (ph && o_macrotick == MT_LAST) begin
                o_macrotick <= 14'h0;
                o_cycle_count <= o_cycle_count + 6'h1; // Wraps 63 to 0
                o_cycle_start <= 1'b1;
            end else if (ph) begin
                o_macrotick <= o_macrotick + 14'h1;
            end
        end
    end
endmodule // rftis_engine_model

// ==== rftis_core_tb_top.sv ====
// Self-checking bench for the receive queue, timers and interrupts.
// Host side speaks Avalon-MM; the engine model drives the counters.
module rftis_core_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic i_core_clk = 0, i_rst_n = 0, rdq = 0, wrq = 0, va = 0, vb = 0;
    logic ab = 0;
    logic [2:0] st = 3'h2;
    logic [7:0] adr = 8'h0, len = 8'h20;
    logic [31:0] wd = 32'h0, rd;
    logic [255:0] pa = 256'h0, pb = 256'h0;
    logic [15:0] sa = 16'h0, sb = 16'h0;
    logic [5:0] c;
    logic [1:0] rs;
    wire [31:0] rdata;
    wire [1:0] resp;
    wire [13:0] mt;
    wire [5:0] cyc;
    wire wreq, irq0, irqs, cs;
    int n_errors = 0, checks = 0;
    always #2.5 i_core_clk = ~i_core_clk;
    rftis_engine_model rftis_engine_model_inst (.i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n), .o_macrotick(mt), .o_cycle_count(cyc),
        .o_cycle_start(cs));
    rftis_core rftis_core_inst (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
        .i_avs_address(adr), .i_avs_read(rdq), .i_avs_write(wrq),
        .i_avs_writedata(wd), .i_avs_byteenable(4'hF),
        .o_avs_readdata(rdata), .o_avs_waitrequest(wreq),
        .o_avs_response(resp), .i_rx_a_valid(va), .i_rx_a_payload(pa),
        .i_rx_a_len(len), .i_rx_a_status(sa), .i_rx_b_valid(vb),
        .i_rx_b_payload(pb), .i_rx_b_len(len), .i_rx_b_status(sb),
        .i_macrotick(mt), .i_cycle_count(cyc), .i_cycle_start(cs),
        .i_protocol_state(st), .i_abrupt_cmd(ab), .o_irq_timer0(irq0),
        .o_irq_shared(irqs));
    task chk(input logic [31:0] seen, input logic [31:0] e, input string nm);
        checks++;
        if (seen !== e) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", nm, e, seen);
        end
    endtask
    task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        adr <= a;
        wrq <= w;
        rdq <= !w;
        wd <= d;
        do begin
            @(posedge i_core_clk);
            n++;
        end while (wreq !== 1'b0 && n < 64);
        rd = rdata;
        rs = resp;
        rdq <= 1'b0;
        wrq <= 1'b0;
        if (n >= 64) begin
            n_errors++;
            summarize();
        end
        // Let registered request lines follow a committed write
        repeat (2) @(posedge i_core_clk);
    endtask
    task rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
        input string nm);
        acc(1'b0, a, 32'h0);
        chk(rd & m, e, nm);
    endtask
    task push(input logic two, input logic [7:0] id);
        pa <= {248'h0, id};
        sa <= {8'h0, id};
        pb <= {248'h0, id + 8'h1};
        sb <= {8'h0, id + 8'h1};
        va <= 1'b1;
        vb <= two;
        @(posedge i_core_clk);
        va <= 1'b0;
        vb <= 1'b0;
        @(posedge i_core_clk);
    endtask
    task wirq(input logic t0);
        int n;
        n = 0;
        while ((t0 ? irq0 : irqs) !== 1'b1 && n < 400) begin
            @(posedge i_core_clk);
            n++;
        end
        chk({31'h0, t0 ? irq0 : irqs}, 32'h1, "irq");
    endtask
    task summarize;
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        #(40000 * 5);
        n_errors++;
        summarize();
    end
    initial begin
        repeat (16) @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        @(posedge i_core_clk);
        rdc(8'h04, 32'hFFFFFFFF, 32'h2, "qcfg");
        rdc(8'h00, 32'hFFFFFFFF, 32'h800, "qstat");
        rdc(8'h20, 32'hFFFFFFFF, 32'h0, "ien");
        acc(1'b0, 8'h30, 32'h0);
        chk({30'h0, rs}, 32'h2, "hole");
        $display("reset done");
        acc(1'b1, 8'h04, 32'h420);
        push(1'b1, 8'h0); // Both channels at once
        push(1'b1, 8'h2);
        push(1'b0, 8'h4);
        push(1'b0, 8'h5);
        push(1'b1, 8'h6);
        push(1'b0, 8'h8); // Ninth frame must be dropped
        rdc(8'h00, 32'hFFFFFFFF, 32'h10008, "full");
        rdc(8'h1C, 32'h10, 32'h10, "thr");
        for (int i = 0; i < 8; i++) begin
            rdc(8'h40, 32'hFFFFFFFF, i, "order");
            acc(1'b0, 8'h0C, 32'h0);
        end
        rdc(8'h00, 32'hFFFFFFFF, 32'h10800, "sticky");
        acc(1'b1, 8'h00, 32'h10000);
        rdc(8'h00, 32'hFFFFFFFF, 32'h800, "ovr clr");
        $display("queue done");
        acc(1'b1, 8'h20, 32'h80000010);
        chk({31'h0, irqs}, 32'h1, "on");
        acc(1'b1, 8'h24, 32'h10);
        chk({31'h0, irqs}, 32'h0, "unmapped");
        acc(1'b1, 8'h24, 32'h0);
        acc(1'b1, 8'h20, 32'h10);
        chk({31'h0, irqs}, 32'h0, "global");
        rdc(8'h1C, 32'h10, 32'h10, "flag");
        acc(1'b1, 8'h20, 32'h80000010);
        acc(1'b1, 8'h1C, 32'h1F);
        chk({31'h0, irqs}, 32'h0, "w1c");
        $display("irq done");
        st <= 3'h3;
        acc(1'b1, 8'h10, {10'h0, 1'b1, 1'b0, 6'h0, 14'hA});
        acc(1'b1, 8'h18, 32'h1);
        acc(1'b1, 8'h20, 32'h80000001);
        rdc(8'h1C, 32'h8, 32'h8, "enter full");
        wirq(1'b1);
        st <= 3'h4; // Full to listen keeps timers
        acc(1'b1, 8'h1C, 32'h1F);
        wirq(1'b1);
        c = cyc + 6'h2;
        acc(1'b1, 8'h14, {10'h0, 1'b0, 1'b1, c, 14'h5});
        acc(1'b1, 8'h18, 32'h3);
        acc(1'b1, 8'h20, 32'h80000002);
        wirq(1'b0);
        chk({26'h0, cyc}, {26'h0, c}, "t1 cycle");
        ab <= 1'b1;
        st <= 3'h2;
        acc(1'b1, 8'h1C, 32'h1F);
        ab <= 1'b0;
        repeat (100) @(posedge i_core_clk);
        rdc(8'h1C, 32'hB, 32'h0, "left");
        st <= 3'h1;
        repeat (100) @(posedge i_core_clk);
        rdc(8'h1C, 32'hC, 32'hC, "halt");
        $display("timer done");
        summarize();
    end
endmodule // rftis_core_tb_top
